/* File: logic/tc_consts.svh */
`ifndef TC_CONSTS_SVH
`define TC_CONSTS_SVH
// timing
`define CLK_PERIOD_NS 8
`define SETTLE_MS 250
`define TICK_MS 1
`define TACHO_WINDOW_TICKS 1000
// register byte addresses
`define ADDR_CTRL 8'h00
`define ADDR_SET1 8'h04
`define ADDR_SET2 8'h08
`define ADDR_PV 8'h0c
`define ADDR_PV_B 8'h10
`define ADDR_AUX 8'h14
`define ADDR_STATUS 8'h18
`define ADDR_KEY 8'h1c
// ctrl fields
`define CTRL_FUNC_LSB 0
`define CTRL_POD_BIT 4
`define CTRL_REMAIN_BIT 5
`define CTRL_ABS_BIT 6
`define CTRL_ARR_LSB 7
`define CTRL_SHOW_BIT 10
`define KEY_PRESS_BIT 0
`endif

/* File: logic/tc_pkg.sv */
package tc_pkg;
   typedef logic [23:0] value_t;
   typedef enum logic [3:0] {fn_timer, fn_twin, fn_two_stage, fn_count1, fn_count2, fn_total, fn_batch,
      fn_dual, fn_tacho} func_e;
   typedef enum logic [2:0] {arr_inc, arr_dec, arr_cmd, arr_indiv, arr_quad} arrange_e;
   typedef enum logic {bus_idle, bus_ack} bus_e;
   typedef struct packed {
      func_e func;
      logic pod_mode;
      logic remaining;
      logic absolute;
      arrange_e arrange;
      logic show_aux;
   } cfg_s;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_s;
   typedef struct packed {
      logic start_input;
      logic gate_input;
      logic first_reset_input;
      logic second_reset_input;
      logic count_input_a;
      logic count_input_b;
   } term_in_s;
   typedef struct packed {
      logic first_control_output;
      logic second_control_output;
      logic reset_indicator;
   } drive_s;
   typedef struct packed {
      cfg_s cfg;
      value_t set1;
      value_t set2;
      value_t pv;
      value_t pv_b;
      value_t aux;
      value_t rate;
      logic [31:0] settle_cnt;
      logic [31:0] tick_cnt;
      logic [15:0] win_cnt;
      logic started;
      logic hold;
      logic a_q;
      logic b_q;
      logic start_q;
      bus_e bus;
      apb_rsp_s rsp;
      drive_s drv;
   } state_s;
endpackage

/* File: logic/timer_counter_io.sv */
// Contract
// - counter key press clears value and outputs
// - total key clears total when shown
// - batch key clears value, first output
// - dual key clears both channels, sum, outputs
// - tachometer key toggles the freeze of value and outputs
// - start stops power-on-delay, else starts timing
// - timer reset loads zero or set value
// - timer reset: no counting, outputs off, lamp
// - single/twin outputs switch at set values
// - two-stage reset returns zero, outputs off
// - forecast: second at set, first earlier
// - absolute: outputs at set one, two
// - count input arrangements outside dual mode
// - dual: each input counts up alone
// - counter reset clears, blocks, lights lamp
// - dual resets clear own channel only
// - stage counters ignore second reset
// - total reset holds total at zero
// - batch reset clears batch count, output
// - reset value zero or set value
// - second reset lights lamp in tachometer mode only
// - tachometer resets hold measurement, light lamp
// - outputs off, inputs ignored while settling
//
// The implementer's own choices: register access over APB and the register addresses.
`include "tc_consts.svh"
module timer_counter_io #(
   parameter int unsigned settle_cycles = `SETTLE_MS * 1000000 / `CLK_PERIOD_NS,
   parameter int unsigned tick_cycles = `TICK_MS * 1000000 / `CLK_PERIOD_NS,
   parameter int unsigned window_ticks = `TACHO_WINDOW_TICKS
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // register bus
   input wire tc_pkg::apb_req_s apb_req,
   output tc_pkg::apb_rsp_s apb_rsp,
   // terminals
   input wire tc_pkg::term_in_s term_in,
   output tc_pkg::drive_s term_out
);
   tc_pkg::state_s st;
   tc_pkg::state_s next_st;
   logic settling;
   logic tick;
   logic win_end;
   logic a_rise;
   logic b_rise;
   logic start_rise;
   logic up;
   logic down;
   logic dec;
   logic timer_fn;
   logic counter_fn;
   logic pod;
   logic run;
   logic hold_eff;
   logic key;
   tc_pkg::value_t home;
   tc_pkg::value_t t1;
   tc_pkg::value_t t2;
   tc_pkg::value_t t_end;
   tc_pkg::value_t elapsed;

   function automatic tc_pkg::value_t sub0(input tc_pkg::value_t a, input tc_pkg::value_t b);
      sub0 = (a > b) ? a - b : '0;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'b00) && (a <= `ADDR_KEY);
   endfunction

   assign apb_rsp = st.rsp;
   assign term_out = st.drv;

   always_comb begin
      next_st = st;
      key = 1'b0;
      settling = st.settle_cnt != 32'h0;
      tick = st.tick_cnt == tick_cycles[31:0] - 32'h1;
      win_end = tick && (st.win_cnt == window_ticks[15:0] - 16'h1);
      a_rise = term_in.count_input_a && !st.a_q;
      b_rise = term_in.count_input_b && !st.b_q;
      start_rise = term_in.start_input && !st.start_q;
      next_st.a_q = term_in.count_input_a;
      next_st.b_q = term_in.count_input_b;
      next_st.start_q = term_in.start_input;
      next_st.tick_cnt = tick ? 32'h0 : st.tick_cnt + 32'h1;
      if (tick) begin
         next_st.win_cnt = win_end ? 16'h0 : st.win_cnt + 16'h1;
      end
      timer_fn = st.cfg.func inside {tc_pkg::fn_timer, tc_pkg::fn_twin, tc_pkg::fn_two_stage};
      counter_fn = st.cfg.func inside {tc_pkg::fn_count1, tc_pkg::fn_count2, tc_pkg::fn_total, tc_pkg::fn_batch};
      dec = st.cfg.arrange == tc_pkg::arr_dec;
      pod = st.cfg.pod_mode && st.cfg.func != tc_pkg::fn_two_stage;
      run = pod ? !st.started : st.started;
      hold_eff = st.hold || term_in.first_reset_input || term_in.second_reset_input;
      up = 1'b0;
      down = 1'b0;
      home = '0;
      t1 = st.set1;
      t2 = st.set1;
      t_end = st.set1;
      elapsed = '0;

      // register bus
      next_st.rsp.pready = 1'b0;
      unique case (st.bus)
         tc_pkg::bus_idle: begin
            if (apb_req.psel && apb_req.penable) begin
               next_st.bus = tc_pkg::bus_ack;
               next_st.rsp.pready = 1'b1;
               next_st.rsp.pslverr = !mapped(apb_req.paddr);
               case (apb_req.paddr)
                  `ADDR_CTRL: next_st.rsp.prdata = {21'h0, st.cfg.show_aux, st.cfg.arrange, st.cfg.absolute,
                     st.cfg.remaining, st.cfg.pod_mode, st.cfg.func};
                  `ADDR_SET1: next_st.rsp.prdata = {8'h0, st.set1};
                  `ADDR_SET2: next_st.rsp.prdata = {8'h0, st.set2};
                  `ADDR_PV: next_st.rsp.prdata = {8'h0, st.pv};
                  `ADDR_PV_B: next_st.rsp.prdata = {8'h0, st.pv_b};
                  `ADDR_AUX: next_st.rsp.prdata = {8'h0, st.aux};
                  `ADDR_STATUS: next_st.rsp.prdata = {26'h0, settling, st.hold, st.started, st.drv};
                  default: next_st.rsp.prdata = 32'h0;
               endcase
            end
         end
         tc_pkg::bus_ack: begin
            next_st.bus = tc_pkg::bus_idle;
            next_st.rsp.pslverr = 1'b0;
            if (apb_req.pwrite && mapped(apb_req.paddr)) begin
               case (apb_req.paddr)
                  `ADDR_CTRL: begin
                     next_st.cfg.func = tc_pkg::func_e'(apb_req.pwdata[`CTRL_FUNC_LSB +: 4]);
                     next_st.cfg.pod_mode = apb_req.pwdata[`CTRL_POD_BIT];
                     next_st.cfg.remaining = apb_req.pwdata[`CTRL_REMAIN_BIT];
                     next_st.cfg.absolute = apb_req.pwdata[`CTRL_ABS_BIT];
                     next_st.cfg.arrange = tc_pkg::arrange_e'(apb_req.pwdata[`CTRL_ARR_LSB +: 3]);
                     next_st.cfg.show_aux = apb_req.pwdata[`CTRL_SHOW_BIT];
                  end
                  `ADDR_SET1: next_st.set1 = apb_req.pwdata[23:0];
                  `ADDR_SET2: next_st.set2 = apb_req.pwdata[23:0];
                  `ADDR_KEY: key = apb_req.pwdata[`KEY_PRESS_BIT];
                  default: ;
               endcase
            end
         end
      endcase

      if (settling) begin
         next_st.settle_cnt = st.settle_cnt - 32'h1;
         next_st.drv = '0;
      end else begin
         unique case (st.cfg.func)
            tc_pkg::fn_timer, tc_pkg::fn_twin, tc_pkg::fn_two_stage: begin
               home = (st.cfg.remaining && st.cfg.func != tc_pkg::fn_two_stage) ? st.set1 : '0;
               if (st.cfg.func == tc_pkg::fn_twin) begin
                  t2 = st.set2;
               end else if (st.cfg.func == tc_pkg::fn_two_stage) begin
                  if (st.cfg.absolute) begin
                     t2 = st.set2;
                  end else begin
                     t1 = sub0(st.set1, st.set2);
                  end
               end
               t_end = (t1 > t2) ? t1 : t2;
               if (start_rise) begin
                  next_st.started = 1'b1;
               end
               if (term_in.first_reset_input) begin
                  next_st.pv = home;
                  next_st.drv.first_control_output = 1'b0;
                  next_st.drv.second_control_output = 1'b0;
                  next_st.drv.reset_indicator = 1'b1;
               end else begin
                  next_st.drv.reset_indicator = 1'b0;
                  if (run && !term_in.gate_input && tick) begin
                     if (home != '0) begin
                        if (st.pv != '0) begin
                           next_st.pv = st.pv - 24'h1;
                        end
                     end else if (st.pv < t_end) begin
                        next_st.pv = st.pv + 24'h1;
                     end
                  end
                  elapsed = (home != '0) ? sub0(st.set1, next_st.pv) : next_st.pv;
                  next_st.drv.first_control_output = elapsed >= t1;
                  next_st.drv.second_control_output = elapsed >= t2;
               end
            end
            tc_pkg::fn_count1, tc_pkg::fn_count2, tc_pkg::fn_total, tc_pkg::fn_batch: begin
               home = dec ? ((st.cfg.func == tc_pkg::fn_count2) ? st.set2 : st.set1) : '0;
               unique case (st.cfg.arrange)
                  tc_pkg::arr_inc: up = a_rise;
                  tc_pkg::arr_dec: down = a_rise;
                  tc_pkg::arr_cmd: begin
                     up = a_rise && !term_in.count_input_b;
                     down = a_rise && term_in.count_input_b;
                  end
                  tc_pkg::arr_indiv: begin
                     up = a_rise;
                     down = b_rise;
                  end
                  tc_pkg::arr_quad: begin
                     up = a_rise && !term_in.count_input_b;
                     down = a_rise && term_in.count_input_b;
                  end
                  default: ;
               endcase
               if (term_in.first_reset_input) begin
                  next_st.pv = home;
                  next_st.drv = '0;
                  next_st.drv.reset_indicator = 1'b1;
               end else begin
                  next_st.drv.reset_indicator = 1'b0;
                  if (up && !down) begin
                     next_st.pv = st.pv + 24'h1;
                  end else if (down && !up) begin
                     next_st.pv = st.pv - 24'h1;
                  end
                  unique case (st.cfg.func)
                     tc_pkg::fn_count1: begin
                        next_st.drv.first_control_output = dec ? next_st.pv == '0 : next_st.pv >= st.set1;
                        next_st.drv.second_control_output = next_st.drv.first_control_output;
                     end
                     tc_pkg::fn_count2: begin
                        next_st.drv.first_control_output =
                           dec ? next_st.pv <= sub0(st.set2, st.set1) : next_st.pv >= st.set1;
                        next_st.drv.second_control_output = dec ? next_st.pv == '0 : next_st.pv >= st.set2;
                     end
                     tc_pkg::fn_total: begin
                        if (up && !down) begin
                           next_st.aux = st.aux + 24'h1;
                        end
                        next_st.drv.first_control_output = next_st.pv >= st.set1;
                        next_st.drv.second_control_output = next_st.pv >= st.set1;
                     end
                     default: begin
                        if (st.pv != st.set1 && next_st.pv == st.set1) begin
                           next_st.aux = st.aux + 24'h1;
                        end
                        next_st.drv.second_control_output = next_st.pv >= st.set1;
                        next_st.drv.first_control_output = st.drv.first_control_output ||
                           (st.set2 != '0 && next_st.aux >= st.set2);
                     end
                  endcase
               end
               // stage counters leave the second reset unused
               if (term_in.second_reset_input) begin
                  if (st.cfg.func == tc_pkg::fn_total) begin
                     next_st.aux = '0;
                  end else if (st.cfg.func == tc_pkg::fn_batch) begin
                     next_st.aux = '0;
                     next_st.drv.first_control_output = 1'b0;
                  end
               end
            end
            tc_pkg::fn_dual: begin
               if (term_in.first_reset_input) begin
                  next_st.pv = '0;
               end else if (a_rise) begin
                  next_st.pv = st.pv + 24'h1;
               end
               if (term_in.second_reset_input) begin
                  next_st.pv_b = '0;
               end else if (b_rise) begin
                  next_st.pv_b = st.pv_b + 24'h1;
               end
               next_st.aux = next_st.pv + next_st.pv_b;
               next_st.drv.first_control_output = next_st.aux >= st.set1;
               next_st.drv.second_control_output = next_st.aux >= st.set2;
               next_st.drv.reset_indicator = term_in.first_reset_input;
            end
            tc_pkg::fn_tacho: begin
               next_st.drv.reset_indicator = hold_eff;
               if (!hold_eff) begin
                  if (win_end) begin
                     next_st.pv = st.rate + {23'h0, a_rise};
                     next_st.rate = '0;
                  end else begin
                     next_st.rate = st.rate + {23'h0, a_rise};
                  end
                  next_st.drv.first_control_output = next_st.pv >= st.set1;
                  next_st.drv.second_control_output = next_st.pv >= st.set2;
               end
            end
            default: next_st.drv = '0;
         endcase

         // reset key
         if (key) begin
            unique case (st.cfg.func)
               tc_pkg::fn_count1, tc_pkg::fn_count2: begin
                  next_st.pv = home;
                  next_st.drv.first_control_output = 1'b0;
                  next_st.drv.second_control_output = 1'b0;
               end
               tc_pkg::fn_total: begin
                  next_st.pv = home;
                  next_st.drv.first_control_output = 1'b0;
                  next_st.drv.second_control_output = 1'b0;
                  if (st.cfg.show_aux) begin
                     next_st.aux = '0;
                  end
               end
               tc_pkg::fn_batch: begin
                  next_st.pv = home;
                  next_st.drv.first_control_output = 1'b0;
                  if (st.cfg.show_aux) begin
                     next_st.aux = '0;
                     next_st.drv.second_control_output = 1'b0;
                  end
               end
               tc_pkg::fn_dual: begin
                  next_st.pv = '0;
                  next_st.pv_b = '0;
                  next_st.aux = '0;
                  next_st.drv.first_control_output = 1'b0;
                  next_st.drv.second_control_output = 1'b0;
               end
               tc_pkg::fn_tacho: next_st.hold = !st.hold;
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st <= '0;
         st.settle_cnt <= settle_cycles[31:0];
      end else begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   sequence s_ctr_reset;
      !settling && counter_fn && term_in.first_reset_input;
   endsequence
   sequence s_timer_reset;
      !settling && timer_fn && term_in.first_reset_input;
   endsequence
   sequence s_start;
      !settling && timer_fn && start_rise;
   endsequence
   sequence s_outputs_off;
      !st.drv.first_control_output && !st.drv.second_control_output;
   endsequence

   settle_quiet_a: assert property (settling |-> st.drv == '0)
      else $error("output active while settling");
   ctr_reset_a: assert property (s_ctr_reset |=> st.pv == $past(home) ##0 s_outputs_off ##0 st.drv.reset_indicator)
      else $error("counter reset not applied");
   key_clear_a: assert property (!settling && key && st.cfg.func inside {tc_pkg::fn_count1, tc_pkg::fn_count2}
      |=> st.pv == $past(home) ##0 s_outputs_off)
      else $error("key press did not clear counter");
   total_key_a: assert property (!settling && key && st.cfg.func == tc_pkg::fn_total && st.cfg.show_aux
      |=> st.aux == '0 && st.pv == $past(home))
      else $error("key press did not clear total");
   batch_key_a: assert property (!settling && key && st.cfg.func == tc_pkg::fn_batch
      |=> !st.drv.first_control_output && st.pv == $past(home))
      else $error("key press did not clear batch output");
   dual_key_a: assert property (!settling && key && st.cfg.func == tc_pkg::fn_dual
      |=> st.pv == '0 && st.pv_b == '0 && st.aux == '0)
      else $error("key press did not clear dual values");
   dual_reset_a: assert property (!settling && st.cfg.func == tc_pkg::fn_dual && term_in.second_reset_input
      |=> st.pv_b == '0 && st.drv.reset_indicator == $past(term_in.first_reset_input))
      else $error("second channel reset wrong");
   total_hold_a: assert property (!settling && st.cfg.func == tc_pkg::fn_total && term_in.second_reset_input
      |=> st.aux == '0)
      else $error("total not held at zero");
   batch_hold_a: assert property (!settling && st.cfg.func == tc_pkg::fn_batch && term_in.second_reset_input
      |=> st.aux == '0 && !st.drv.first_control_output)
      else $error("batch count not held at zero");
   lamp_quiet_a: assert property (!settling && counter_fn && term_in.second_reset_input
      && !term_in.first_reset_input |=> !st.drv.reset_indicator)
      else $error("lamp lit by second reset");
   timer_reset_a: assert property (s_timer_reset |=> st.pv == $past(home) ##0 s_outputs_off
      ##0 st.drv.reset_indicator)
      else $error("timer reset not applied");
   gate_hold_a: assert property (!settling && timer_fn && term_in.gate_input && !term_in.first_reset_input
      |=> $stable(st.pv))
      else $error("timer moved under gate");
   pod_start_a: assert property (s_start |=> run == !pod)
      else $error("start input acted wrongly");
   tacho_hold_a: assert property (!settling && st.cfg.func == tc_pkg::fn_tacho && hold_eff
      |=> $stable(st.pv) && $stable(st.drv.first_control_output) && st.drv.reset_indicator == $past(hold_eff))
      else $error("tachometer hold broken");
endmodule

/* File: verif/tb_timer_counter_io_reset_logic.sv */
`include "tc_consts.svh"
module tb_timer_counter_io_reset_logic;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   tc_pkg::apb_req_s apb_req = '0;
   tc_pkg::apb_rsp_s apb_rsp;
   tc_pkg::term_in_s levels = '0;
   tc_pkg::term_in_s term_in;
   tc_pkg::drive_s term_out;
   logic burst_a = 1'b0;
   logic burst_b = 1'b0;
   logic [31:0] rdat;
   logic rerr;
   int failures = 0;
   int tests_run = 0;
   timer_counter_io #(.settle_cycles(20), .tick_cycles(4), .window_ticks(4)) uut (.mclk(mclk),
      .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp), .term_in(term_in), .term_out(term_out));
   terminal_model far (.mclk(mclk), .levels(levels), .burst_a(burst_a), .burst_b(burst_b),
      .term(term_in));
   initial begin
      forever #4 mclk = ~mclk;
   end
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge mclk);
      apb_req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         failures++;
         $display("wrong value at %0t: no bus answer", $time);
      end
      rdat = apb_rsp.prdata;
      rerr = apb_rsp.pslverr;
      apb_req <= '0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic lv(input logic [5:0] v);
      @(posedge mclk);
      levels <= v;
      idle(3);
   endtask
   task automatic pulse(input logic a, input logic b);
      @(posedge mclk);
      burst_a <= a;
      burst_b <= b;
      @(posedge mclk);
      burst_a <= 1'b0;
      burst_b <= 1'b0;
      idle(6);
   endtask
   task automatic t_counter();
      wr(`ADDR_CTRL, 32'h3);
      wr(`ADDR_SET1, 32'h2);
      pulse(1, 0);
      pulse(1, 0);
      bus(0, `ADDR_PV, 0);
      chk(rdat, 32'h2);
      chk({29'h0, term_out}, 32'h6);
      wr(`ADDR_KEY, 32'h1);
      idle(3);
      chk({29'h0, term_out}, 32'h0);
      bus(0, `ADDR_PV, 0);
      chk(rdat, 32'h0);
      lv(6'h04);
      pulse(1, 0);
      chk({29'h0, term_out}, 32'h0);
      bus(0, `ADDR_PV, 0);
      chk(rdat, 32'h1);
      lv(6'h08);
      pulse(1, 0);
      chk({29'h0, term_out}, 32'h1);
      bus(0, `ADDR_PV, 0);
      chk(rdat, 32'h0);
      lv(6'h00);
      wr(`ADDR_CTRL, 32'h83);
      lv(6'h08);
      lv(6'h00);
      bus(0, `ADDR_PV, 0);
      chk(rdat, 32'h2);
   endtask
   task automatic t_dual();
      wr(`ADDR_CTRL, 32'h7);
      wr(`ADDR_SET1, 32'h3);
      wr(`ADDR_SET2, 32'h5);
      wr(`ADDR_KEY, 32'h1);
      pulse(1, 1);
      pulse(1, 0);
      bus(0, `ADDR_PV_B, 0);
      chk(rdat, 32'h1);
      bus(0, `ADDR_AUX, 0);
      chk(rdat, 32'h3);
      chk({29'h0, term_out}, 32'h4);
      wr(`ADDR_KEY, 32'h1);
      idle(3);
      chk({29'h0, term_out}, 32'h0);
      bus(0, `ADDR_PV, 0);
      chk(rdat, 32'h0);
      bus(0, `ADDR_AUX, 0);
      chk(rdat, 32'h0);
   endtask
   task automatic t_timer();
      wr(`ADDR_CTRL, 32'h0);
      wr(`ADDR_SET1, 32'h3);
      lv(6'h08);
      lv(6'h10);
      bus(0, `ADDR_PV, 0);
      chk(rdat, 32'h0);
      lv(6'h30);
      lv(6'h10);
      idle(20);
      bus(0, `ADDR_PV, 0);
      chk(rdat, 32'h0);
      lv(6'h00);
      idle(20);
      chk({29'h0, term_out}, 32'h6);
      lv(6'h08);
      chk({29'h0, term_out}, 32'h1);
      bus(0, `ADDR_PV, 0);
      chk(rdat, 32'h0);
      lv(6'h00);
   endtask
   initial begin
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      pulse(1, 0);
      bus(0, `ADDR_STATUS, 0);
      chk({31'h0, rdat[5]}, 32'h1);
      chk({29'h0, term_out}, 32'h0);
      idle(25);
      bus(0, 8'h20, 0);
      chk({31'h0, rerr}, 32'h1);
      chk(rdat, 32'h0);
      t_counter();
      t_dual();
      t_timer();
      end_sim();
   end
   initial begin
      repeat (5000) @(posedge mclk);
      failures++;
      end_sim();
   end
endmodule

/* File: verif/terminal_model.sv */
module terminal_model (
   // clock
   input wire logic mclk,
   // switch levels and pulse requests
   input wire tc_pkg::term_in_s levels,
   input wire logic burst_a,
   input wire logic burst_b,
   // terminals
   output tc_pkg::term_in_s term
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ph_a = 2'h0;
   logic [1:0] ph_b = 2'h0;
   // one request gives one sensor pulse, high for two cycles
   always_ff @(posedge mclk) begin
      ph_a <= (burst_a || ph_a != 2'h0) ? ph_a + 2'h1 : 2'h0;
      ph_b <= (burst_b || ph_b != 2'h0) ? ph_b + 2'h1 : 2'h0;
   end
   always_comb begin
      term = levels;
      term.count_input_a = ph_a[0] ^ ph_a[1];
      term.count_input_b = ph_b[0] ^ ph_b[1];
   end
endmodule
